// File: debug_port_halt_and_chip_erase.v
// Debugger detect filter, pin claim, core hold and chip erase sequencer
// How it works
// R1: One physical connection carries either scan or two-wire debug port
// R2: Boundary scan controller runs beside the scan debug port
// R3: Filter watches test clock and reset pin for debugger and hold
// R4: Detected debugger claims the scan pins for the debug block
// R5: Two-wire mode hands data-in and data-out pins back
// R6: Triggered halt keeps core in reset after external reset release
// R7: Power manager start moves core, system, flash, bus clocks to slow clock
// R8: Debug and access ports clocked and released while reset pin low
// R9: Debugger holds test clock low while releasing reset to halt
// R10: Reset release with test clock low asserts the core hold
// R11: Writing one to the chip erase bit starts a chip erase
// R12: Erase clears volatile memories, then flash, then protected state
// R13: User page of flash is never erased
// R14: Done flag set when erase completes; debugger polls it
// R15: Debugger restarts chip by reset pin or power cycle after erase
// R16: Debugger keeps test clock high on release to avoid halt
// R17: New protected state takes effect only after chip reset
// R18: Test clock level sampled at reset release decides the hold
`timescale 1ns/100ps
`default_nettype none
`include "debug_port_defines.vh"

module debug_port_halt_and_chip_erase #(
    parameter integer DETECT_EDGES = `DETECT_EDGES
) (
    // Clock, reset and enable
    input wire core_clk,
    input wire resetn,
    input wire clkEn,
    // Debugger pins, outside the clock domain
    input wire testClkPin,
    input wire extResetPinN,
    // Power, mode and erase controls
    input wire powerManagerStarted,
    input wire twoWireModeSel,
    input wire chipEraseBitWrite,
    // Handshakes from the memory controllers
    input wire volatileClearDone,
    input wire flashClearDone,
    input wire protectClearDone,
    input wire protectProgrammed,
    // Pin ownership and debug port variant
    output reg debuggerPresent,
    output reg scanPinsClaimed,
    output reg dataPinsClaimed,
    output reg scanPortActive,
    output reg twoWirePortActive,
    output reg boundaryScanActive,
    // Clock and reset controls
    output reg slowClockSel,
    output reg debugPortClkEn,
    output reg debugPortResetN,
    output reg systemResetN,
    output reg coreResetHold,
    // Erase requests and status
    output reg volatileClearReq,
    output reg flashClearReq,
    output reg userPageErase,
    output reg protectClearReq,
    output reg eraseBusy,
    output reg erase_done_flag,
    output reg protectActive
);

    // Parked level of each pin in reset: test clock high, reset pin low
    localparam [`PIN_COUNT-1:0] PIN_PARK = {`RST_PARK_LEVEL, `TCK_PARK_LEVEL};
    // Last count before the detect threshold
    localparam [3:0] DETECT_LAST = DETECT_EDGES[3:0] - 4'h1;

    // Two-stage synchronisers for the pins from outside the clock domain;
    // only the second stage feeds logic, so a metastable first stage never spreads
    wire [`PIN_COUNT-1:0] pinRaw = {extResetPinN, testClkPin};
    wire [`PIN_COUNT-1:0] pinSync;
    wire [`PIN_COUNT-1:0] pinPrev;
    genvar pinIdx;
    generate
        for (pinIdx = 0; pinIdx < `PIN_COUNT; pinIdx = pinIdx + 1) begin : gPinSync
            reg pinMeta;
            reg pinStage;
            reg pinLast;
            // Parked reset level, so no false edge follows reset while the pin sits at its park level
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    pinMeta <= PIN_PARK[pinIdx];
                    pinStage <= PIN_PARK[pinIdx];
                    pinLast <= PIN_PARK[pinIdx];
                end else if (clkEn) begin
                    pinMeta <= pinRaw[pinIdx];
                    pinStage <= pinMeta;
                    pinLast <= pinStage;
                end
            end
            // Second stage and its delayed copy for edge detection
            assign pinSync[pinIdx] = pinStage;
            assign pinPrev[pinIdx] = pinLast;
        end
    endgenerate

    // Named views of the synchronised pins
    wire tckSync = pinSync[`PIN_TCK];
    wire tckPrev = pinPrev[`PIN_TCK];
    wire rstSync = pinSync[`PIN_RST];
    wire rstPrev = pinPrev[`PIN_RST];

    // Edges of the synchronised pins
    wire tckRise = tckSync & ~tckPrev;
    wire rstRelease = rstSync & ~rstPrev;
    wire rstAssert = ~rstSync & rstPrev;

    // Debugger presence: count test clock edges, cleared only by the block reset
    // Limitation: an unplugged debugger stays flagged until the next block reset
    reg [3:0] edgeCount;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            edgeCount <= 4'h0;
            debuggerPresent <= 1'b0;
        end else if (clkEn) begin
            // Count only until the threshold, so the counter cannot wrap
            if (tckRise && !debuggerPresent) begin // R3
                edgeCount <= edgeCount + 4'h1;
            end
            if (tckRise && edgeCount >= DETECT_LAST) begin
                debuggerPresent <= 1'b1; // R3
            end
            // Hold on the pins also counts as a debugger being attached
            if (rstRelease && !tckSync) begin
                debuggerPresent <= 1'b1; // R3
            end
        end
    end

    // Port variant decode; the data pin claim and the port enables share it,
    // so they can never disagree about the mode
    function portVariantOn;
        input present;
        input modeSel;
        input wanted;
        begin
            portVariantOn = present && (modeSel == wanted);
        end
    endfunction

    // Pin ownership and debug port variant selection
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scanPinsClaimed <= 1'b0;
            dataPinsClaimed <= 1'b0;
            scanPortActive <= 1'b0;
            twoWirePortActive <= 1'b0;
            boundaryScanActive <= 1'b0;
        end else if (clkEn) begin
            // Claims follow presence a cycle later, so pins switch only once decided
            scanPinsClaimed <= debuggerPresent; // R4
            // Two-wire mode frees data-in and data-out for other functions
            dataPinsClaimed <= portVariantOn(debuggerPresent, twoWireModeSel, `MODE_SCAN); // R5
            scanPortActive <= portVariantOn(debuggerPresent, twoWireModeSel, `MODE_SCAN); // R1
            twoWirePortActive <= portVariantOn(debuggerPresent, twoWireModeSel, `MODE_TWO_WIRE); // R1
            // Boundary scan shares the scan pins in parallel with the scan port
            boundaryScanActive <= portVariantOn(debuggerPresent, twoWireModeSel, `MODE_SCAN); // R2
        end
    end

    // Startup filter: clocks, resets and the core hold
    reg [1:0] fltState;
    reg [1:0] next_fltState;
    always @* begin
        next_fltState = fltState;
        case (fltState)
            // Waiting for the power manager; a pin release here is ignored
            `FLT_RESET: begin
                if (powerManagerStarted) begin
                    next_fltState = `FLT_BOOT;
                end
            end
            // Slow clocks and debug port up, waiting for the pin release
            `FLT_BOOT: begin
                if (rstRelease) begin
                    next_fltState = `FLT_RUN;
                end
            end
            // System out of reset until the pin is pulled again
            `FLT_RUN: begin
                if (rstAssert) begin
                    next_fltState = `FLT_RESET;
                end
            end
            default: begin
                next_fltState = `FLT_RESET;
            end
        endcase
    end

    // Slow clocks and the debug port wake while the reset pin is still low
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slowClockSel <= 1'b0;
            debugPortClkEn <= 1'b0;
            debugPortResetN <= 1'b0;
        end else if (clkEn) begin
            if (fltState == `FLT_RESET && powerManagerStarted) begin
                slowClockSel <= 1'b1; // R7
                debugPortClkEn <= 1'b1; // R8
                debugPortResetN <= 1'b1; // R8
            end
        end
    end

    // System reset, core hold and protected state follow the reset pin edges
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fltState <= `FLT_RESET;
            systemResetN <= 1'b0;
            coreResetHold <= 1'b0;
            protectActive <= 1'b0;
        end else if (clkEn) begin
            fltState <= next_fltState;
            if (fltState == `FLT_BOOT && rstRelease) begin
                systemResetN <= 1'b1;
                // Level at the release edge picks halt or normal boot
                coreResetHold <= ~tckSync; // R18 R10 R6
                // Protected state only reloads on a chip restart
                protectActive <= protectProgrammed; // R17
            end
            // Pin pulled again: back to reset, the clocks stay slow
            if (fltState == `FLT_RUN && rstAssert) begin
                systemResetN <= 1'b0;
                coreResetHold <= 1'b0;
            end
        end
    end

    // A start write is taken only in idle or done; writes while busy are dropped
    wire eraseStart = chipEraseBitWrite && !eraseBusy;

    // Chip erase sequencer; busy ignores further start writes
    // Order is fixed: volatile memories, flash array, protected state
    reg [2:0] ersState;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ersState <= `ERS_IDLE;
            volatileClearReq <= 1'b0;
            flashClearReq <= 1'b0;
            userPageErase <= 1'b0;
            protectClearReq <= 1'b0;
            eraseBusy <= 1'b0;
            erase_done_flag <= 1'b0;
        end else if (clkEn) begin
            // User page output is pinned low; no step ever reaches it
            userPageErase <= 1'b0; // R13
            case (ersState)
                `ERS_IDLE: begin
                    if (eraseStart) begin // R11
                        ersState <= `ERS_VOLATILE;
                        volatileClearReq <= 1'b1; // R12
                        eraseBusy <= 1'b1;
                        erase_done_flag <= 1'b0;
                    end
                end
                `ERS_VOLATILE: begin
                    if (volatileClearDone) begin
                        volatileClearReq <= 1'b0;
                        flashClearReq <= 1'b1; // R12
                        ersState <= `ERS_FLASH;
                    end
                end
                `ERS_FLASH: begin
                    if (flashClearDone) begin
                        flashClearReq <= 1'b0;
                        protectClearReq <= 1'b1; // R12
                        ersState <= `ERS_PROTECT;
                    end
                end
                `ERS_PROTECT: begin
                    if (protectClearDone) begin
                        protectClearReq <= 1'b0;
                        eraseBusy <= 1'b0;
                        erase_done_flag <= 1'b1; // R14
                        ersState <= `ERS_DONE;
                    end
                end
                `ERS_DONE: begin
                    // Flag stays until a new erase; restart is the debugger's job
                    if (eraseStart) begin // R11
                        ersState <= `ERS_VOLATILE;
                        volatileClearReq <= 1'b1;
                        eraseBusy <= 1'b1;
                        erase_done_flag <= 1'b0;
                    end
                end
                default: begin
                    ersState <= `ERS_IDLE;
                end
            endcase
        end
    end

endmodule // debug_port_halt_and_chip_erase
`default_nettype wire

// File: debug_port_defines.vh
// Constants for the debug port halt and chip erase front end
`ifndef DEBUG_PORT_DEFINES_VH
`define DEBUG_PORT_DEFINES_VH
// Filter states
`define FLT_RESET 2'h0
`define FLT_BOOT 2'h1
`define FLT_RUN 2'h2
// Erase sequencer states
`define ERS_IDLE 3'h0
`define ERS_VOLATILE 3'h1
`define ERS_FLASH 3'h2
`define ERS_PROTECT 3'h3
`define ERS_DONE 3'h4
// Debug port modes
`define MODE_SCAN 1'b0
`define MODE_TWO_WIRE 1'b1
// Edges of the test clock seen before a debugger counts as present
`define DETECT_EDGES 4'h2
// Synchronised pins: how many, where each sits, and the level each parks at in reset
`define PIN_COUNT 2
`define PIN_TCK 0
`define PIN_RST 1
`define TCK_PARK_LEVEL 1'b1
`define RST_PARK_LEVEL 1'b0
`endif

// File: debug_port_monitor.sv
// Checker for the debug port front end
`timescale 1ns/100ps
`default_nettype none
module debug_port_monitor (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic chipEraseBitWrite,
    input wire logic eraseBusy,
    input wire logic volatileClearReq,
    input wire logic volatileClearDone,
    input wire logic flashClearReq,
    input wire logic flashClearDone,
    input wire logic protectClearReq,
    input wire logic protectClearDone,
    input wire logic erase_done_flag,
    input wire logic userPageErase,
    input wire logic powerManagerStarted,
    input wire logic slowClockSel,
    input wire logic debugPortResetN,
    input wire logic twoWireModeSel,
    input wire logic dataPinsClaimed,
    input wire logic coreResetHold,
    input wire logic systemResetN
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Accepted erase write; busy writes are dropped
    sequence s_go; chipEraseBitWrite && clkEn && !eraseBusy; endsequence
    a_user_page_kept: assert property (!userPageErase) else $error("user page erased");
    a_volatile_first: assert property (s_go |=> volatileClearReq && eraseBusy) else $error("no volatile step");
    a_flash_second: assert property (volatileClearReq && volatileClearDone && clkEn |=> flashClearReq && !volatileClearReq)
        else $error("no flash step");
    a_protect_last: assert property (flashClearReq && flashClearDone && clkEn |=> protectClearReq)
        else $error("no protect step");
    a_done_flagged: assert property (protectClearReq && protectClearDone && clkEn |=> erase_done_flag && !eraseBusy)
        else $error("done missing");
    a_slow_clocks: assert property (powerManagerStarted && clkEn |=> slowClockSel && debugPortResetN)
        else $error("slow clock missing");
    a_data_released: assert property (clkEn && twoWireModeSel ##1 twoWireModeSel |-> !dataPinsClaimed)
        else $error("data pins kept");
    a_hold_released: assert property ($rose(coreResetHold) |-> systemResetN) else $error("hold without release");
endmodule // debug_port_monitor
bind debug_port_halt_and_chip_erase debug_port_monitor debug_port_monitor_i (.core_clk, .resetn, .clkEn,
    .chipEraseBitWrite, .eraseBusy, .volatileClearReq, .volatileClearDone, .flashClearReq, .flashClearDone,
    .protectClearReq, .protectClearDone, .erase_done_flag, .userPageErase, .powerManagerStarted, .slowClockSel,
    .debugPortResetN, .twoWireModeSel, .dataPinsClaimed, .coreResetHold, .systemResetN);
`default_nettype wire

// File: debugger_model.sv
// External debugger driving test clock and reset pin
`timescale 1ns/100ps
`default_nettype none
module debugger_model (
    input wire logic rstHold,
    input wire logic tckRun,
    input wire logic tckIdle,
    output var logic testClkPin,
    output wire logic extResetPinN
);
    // Test clock runs in frames only, else parks at the idle level
    initial begin
        testClkPin = 1'b1;
        forever begin
            #40;
            testClkPin = tckRun ? ~testClkPin : tckIdle;
        end
    end
    // Reset pin follows the request
    assign extResetPinN = ~rstHold;
endmodule // debugger_model
`default_nettype wire

// File: debug_port_halt_and_chip_erase_tb_top.sv
// Bench for the debug port front end
`timescale 1ns/100ps
`default_nettype none
module debug_port_halt_and_chip_erase_tb_top;
    logic core_clk, resetn, clkEn, powerManagerStarted, twoWireModeSel, chipEraseBitWrite, protectProgrammed;
    logic volatileClearDone, flashClearDone, protectClearDone, rstHold, tckRun, tckIdle;
    wire logic testClkPin, extResetPinN;
    logic debuggerPresent, scanPinsClaimed, dataPinsClaimed, scanPortActive, twoWirePortActive, boundaryScanActive;
    logic slowClockSel, debugPortClkEn, debugPortResetN, systemResetN, coreResetHold, volatileClearReq;
    logic flashClearReq, userPageErase, protectClearReq, eraseBusy, erase_done_flag, protectActive;
    int badCount = 0;
    int checksDone = 0;
    debug_port_halt_and_chip_erase #(.DETECT_EDGES(2)) debug_port_halt_and_chip_erase_i (.core_clk, .resetn,
        .clkEn, .testClkPin, .extResetPinN, .powerManagerStarted, .twoWireModeSel, .chipEraseBitWrite,
        .volatileClearDone, .flashClearDone, .protectClearDone, .protectProgrammed, .debuggerPresent,
        .scanPinsClaimed, .dataPinsClaimed, .scanPortActive, .twoWirePortActive, .boundaryScanActive,
        .slowClockSel, .debugPortClkEn, .debugPortResetN, .systemResetN, .coreResetHold, .volatileClearReq,
        .flashClearReq, .userPageErase, .protectClearReq, .eraseBusy, .erase_done_flag, .protectActive);
    debugger_model debugger_model_i (.rstHold, .tckRun, .tckIdle, .testClkPin, .extResetPinN);
    // Core clock, 10 ns period
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task chk(input logic seen, input logic exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // One-cycle pulse on the k-th erase step acknowledge, then a quiet cycle
    task ackStep(input int k);
        {protectClearDone, flashClearDone, volatileClearDone} = 3'h1 << k;
        step(1);
        {protectClearDone, flashClearDone, volatileClearDone} = 3'h0;
        step(1);
    endtask
    task closeOut;
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #100000;
        badCount++;
        closeOut;
    end
    // Power-up with pin held, halt, erase, then a clean restart
    initial begin
        {clkEn, powerManagerStarted, twoWireModeSel, chipEraseBitWrite, protectProgrammed} = 5'h10;
        {volatileClearDone, flashClearDone, protectClearDone, tckRun, tckIdle} = 5'h0;
        rstHold = 1'b1;
        resetn = 1'b0;
        step(3);
        resetn = 1'b1;
        step(2);
        powerManagerStarted = 1'b1;
        step(2);
        chk(slowClockSel, 1'b1);
        chk(debugPortClkEn, 1'b1);
        chk(debugPortResetN, 1'b1);
        chk(systemResetN, 1'b0);
        rstHold = 1'b0;
        step(8);
        chk(coreResetHold, 1'b1);
        chk(systemResetN, 1'b1);
        chk(debuggerPresent, 1'b1);
        chk(scanPinsClaimed, 1'b1);
        chk(dataPinsClaimed, 1'b1);
        // Enable low freezes the pin claim, then two-wire mode releases data pins
        clkEn = 1'b0;
        twoWireModeSel = 1'b1;
        step(3);
        chk(dataPinsClaimed, 1'b1);
        chk(twoWirePortActive, 1'b0);
        clkEn = 1'b1;
        step(3);
        chk(dataPinsClaimed, 1'b0);
        chk(scanPortActive, 1'b0);
        chk(boundaryScanActive, 1'b0);
        chk(twoWirePortActive, 1'b1);
        twoWireModeSel = 1'b0;
        step(3);
        chk(scanPortActive, 1'b1);
        chk(boundaryScanActive, 1'b1);
        protectProgrammed = 1'b1;
        chipEraseBitWrite = 1'b1;
        step(1);
        chk(volatileClearReq, 1'b1);
        chk(eraseBusy, 1'b1);
        step(1);
        chipEraseBitWrite = 1'b0;
        chk(flashClearReq, 1'b0);
        ackStep(0);
        chk(flashClearReq, 1'b1);
        chk(volatileClearReq, 1'b0);
        ackStep(1);
        chk(protectClearReq, 1'b1);
        chk(erase_done_flag, 1'b0);
        ackStep(2);
        step(1);
        chk(erase_done_flag, 1'b1);
        chk(eraseBusy, 1'b0);
        chk(userPageErase, 1'b0);
        chk(protectActive, 1'b0);
        chk(protectClearReq, 1'b0);
        // A second erase from the done state clears the flag until it completes
        chipEraseBitWrite = 1'b1;
        step(1);
        chipEraseBitWrite = 1'b0;
        chk(erase_done_flag, 1'b0);
        chk(volatileClearReq, 1'b1);
        ackStep(0);
        ackStep(1);
        ackStep(2);
        step(1);
        chk(erase_done_flag, 1'b1);
        rstHold = 1'b1;
        step(6);
        chk(coreResetHold, 1'b0);
        tckIdle = 1'b1;
        tckRun = 1'b1;
        step(20);
        tckRun = 1'b0;
        step(10);
        rstHold = 1'b0;
        step(8);
        chk(coreResetHold, 1'b0);
        chk(systemResetN, 1'b1);
        chk(protectActive, 1'b1);
        // Mid-run block reset with the pin released, then a hot-plugged debugger
        resetn = 1'b0;
        step(3);
        resetn = 1'b1;
        step(8);
        chk(debuggerPresent, 1'b0);
        chk(scanPinsClaimed, 1'b0);
        chk(coreResetHold, 1'b0);
        tckRun = 1'b1;
        step(30);
        tckRun = 1'b0;
        step(4);
        chk(debuggerPresent, 1'b1);
        chk(scanPinsClaimed, 1'b1);
        closeOut;
    end
endmodule // debug_port_halt_and_chip_erase_tb_top
`default_nettype wire
